/* core/usart_pkg.sv */
`default_nettype none
package usart_pkg;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CSA = 8'h04;
  localparam logic [7:0] OFF_CSB = 8'h08;
  localparam logic [7:0] OFF_CSC = 8'h0C;
  localparam logic [7:0] OFF_BDLO = 8'h10;
  localparam logic [7:0] OFF_BDHI = 8'h14;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT = 1;
  localparam int CSA_RX_READY = 7;
  localparam int CSA_TX_DONE = 6;
  localparam int CSA_BUF_EMPTY = 5;
  localparam int CSA_DBL = 1;
  localparam int CSB_RXIE = 7;
  localparam int CSB_DONE_IE = 6;
  localparam int CSB_EMPTY_IE = 5;
  localparam int CSB_RX_ON = 4;
  localparam int CSB_TX_ON = 3;
  localparam int CSB_SIZE2 = 2;
  localparam int CSB_RX9 = 1;
  localparam int CSB_TX9 = 0;
  localparam int CSC_SYNC = 6;
  localparam int CSC_PAR_EN = 5;
  localparam int CSC_PAR_ODD = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_SIZE_LO = 1;
  localparam int CSC_SIZE_HI = 2;
  localparam int BDHI_W = 4;
  localparam logic [2:0] SIZE_RESET = 3'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] OS_NORMAL = 4'hF;
  localparam logic [3:0] OS_DOUBLE = 4'h7;
  localparam logic [3:0] OS_SYNC = 4'h1;
  localparam logic [3:0] BITS_MAX = 4'h9;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam int FRAME_W = 13;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10} rx_state_t;
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: return 4'h5;
      3'h1: return 4'h6;
      3'h2: return 4'h7;
      SIZE_NINE: return BITS_MAX;
      default: return BITS_BYTE;
    endcase
  endfunction : char_bits
endpackage : usart_pkg
`default_nettype wire

/* core/usart_core.sv */
// Operation
// - transmitter on: serial output pin driven by transmitter
// - sync mode: device drives sync clock and times bits on it
// - data port write fills buffer; moves to shifter when idle or frame ends
// - loaded shifter sends one frame at divider, double-speed or sync rate
// - below eight bits, upper written data bits ignored
// - nine-bit mode: ninth bit from tx ninth-bit control, set before write
// - buffer-empty flag one when buffer empty, zero while holding data
// - buffer-empty irq held while flag set and enabled; data write clears flag
// - tx done set when frame left shifter and buffer empty
// - tx done cleared by irq service or writing one
// - tx done irq raised when flag set and enabled
// - parity enabled: parity bit after last data bit, before stop
// - clearing transmitter on waits until shifter and buffer empty
// - effectively disabled transmitter releases serial output pin
// - receiver on takes input pin; sync mode reception runs on its own two-tick sample count, not on the sync clock
// - receive starts on valid start bit, samples each bit
// - second stop bit ignored; frame complete at first stop
// - first stop bit copies shift register to receive buffer
// - below eight bits, data read returns zeros in upper bits
// - low start, data lsb first, one or two high stops, idle high
// - parity is xor of data, inverted for odd
// - bit period 16, 8 or 2 times divider plus one
// - rx ready flag one while unread data in receive buffer
`timescale 1ns/1ps
`default_nettype none
module usart_core #(
  parameter int DIV_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [usart_pkg::AW-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [usart_pkg::DW-1:0] i_hwdata,
  input wire logic i_hready,
  output logic [usart_pkg::DW-1:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_rxd,
  input wire logic i_txdone_ack,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rxd_own,
  output logic o_xck,
  output logic o_xck_oe,
  output logic o_irq_empty,
  output logic o_irq_txdone,
  output logic o_irq_rxready
);
  import usart_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    return a == t;
  endfunction : hit

  function automatic logic [8:0] low_mask(input logic [3:0] n);
    return 9'(~(9'h1FF << n));
  endfunction : low_mask

  // parity accumulates only over the live data bits
  function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d,
      input logic [3:0] n, input logic pe, input logic po);
    logic [FRAME_W-1:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = po;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        f[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pe) begin
      f[n+4'h1] = p;
    end
    return f;
  endfunction : build_frame

  logic wr_pend_q, rd_ok, addr_ph;
  logic [7:0] wr_addr_q, a_off;
  logic dbl_q, rxie_q, tdie_q, eie_q, rx_on_q, tx_on_q, tx9_q;
  logic sync_q, par_en_q, par_odd_q, stop2_q;
  logic [2:0] size_q;
  logic [DIV_W-1:0] baud_q, baud_cnt_q;
  logic [3:0] nbits, os_max, ph_q;
  logic tick, bound;
  tx_state_t tx_state_q;
  logic [FRAME_W-1:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [8:0] txbuf_q;
  logic txbuf_full_q, tx_done_q, tx_eff_q, line_q, xck_q;
  logic load, frame_end, done_set;
  rx_state_t rx_state_q;
  logic rx_s1_q, rx_s2_q;
  logic [3:0] rx_os_q, rx_cnt_q;
  logic [8:0] rx_sh_q, rxbuf_q;
  logic rx_ready_q, rx_store, rx_samp;
  logic [7:0] csa_v, csb_v, csc_v;
  logic [DW-1:0] rd_word, hrdata_q;
  logic irq_e_q, irq_d_q, irq_r_q;

  assign addr_ph = i_hsel & i_hready & i_htrans[HTRANS_ACT] & (i_hsize == HSIZE_WORD);
  assign a_off = i_haddr[7:0];
  wire wr_data = wr_pend_q & hit(wr_addr_q, OFF_DATA) & tx_on_q;
  wire wr_csa = wr_pend_q & hit(wr_addr_q, OFF_CSA);
  wire wr_csb = wr_pend_q & hit(wr_addr_q, OFF_CSB);
  wire wr_csc = wr_pend_q & hit(wr_addr_q, OFF_CSC);
  wire wr_bdlo = wr_pend_q & hit(wr_addr_q, OFF_BDLO);
  wire wr_bdhi = wr_pend_q & hit(wr_addr_q, OFF_BDHI);
  assign rd_ok = addr_ph & ~i_hwrite;
  wire rd_data = rd_ok & hit(a_off, OFF_DATA);

  // zero-wait slave: every access completes in its data phase, always OKAY
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
    end else begin
      wr_pend_q <= addr_ph & i_hwrite;
      wr_addr_q <= a_off;
      hrdata_q <= rd_ok ? rd_word : '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dbl_q <= 1'b0;
      {rxie_q, tdie_q, eie_q, rx_on_q, tx_on_q, tx9_q} <= '0;
      {sync_q, par_en_q, par_odd_q, stop2_q} <= '0;
      size_q <= SIZE_RESET;
      baud_q <= '0;
    end else begin
      if (wr_csa) begin
        dbl_q <= i_hwdata[CSA_DBL];
      end
      if (wr_csb) begin
        rxie_q <= i_hwdata[CSB_RXIE];
        tdie_q <= i_hwdata[CSB_DONE_IE];
        eie_q <= i_hwdata[CSB_EMPTY_IE];
        rx_on_q <= i_hwdata[CSB_RX_ON];
        tx_on_q <= i_hwdata[CSB_TX_ON];
        size_q[2] <= i_hwdata[CSB_SIZE2];
        tx9_q <= i_hwdata[CSB_TX9];
      end
      if (wr_csc) begin
        sync_q <= i_hwdata[CSC_SYNC];
        par_en_q <= i_hwdata[CSC_PAR_EN];
        par_odd_q <= i_hwdata[CSC_PAR_ODD];
        stop2_q <= i_hwdata[CSC_STOP2];
        size_q[1:0] <= i_hwdata[CSC_SIZE_HI:CSC_SIZE_LO];
      end
      if (wr_bdlo) begin
        baud_q[7:0] <= i_hwdata[7:0];
      end
      if (wr_bdhi) begin
        baud_q[DIV_W-1:8] <= i_hwdata[DIV_W-9:0];
      end
    end
  end

  always_comb begin
    csa_v = '0;
    csa_v[CSA_RX_READY] = rx_ready_q;
    csa_v[CSA_TX_DONE] = tx_done_q;
    csa_v[CSA_BUF_EMPTY] = ~txbuf_full_q;
    csa_v[CSA_DBL] = dbl_q;
    csb_v = {rxie_q, tdie_q, eie_q, rx_on_q, tx_on_q, size_q[2], rxbuf_q[8], tx9_q};
    csc_v = '0;
    csc_v[CSC_SYNC] = sync_q;
    csc_v[CSC_PAR_EN] = par_en_q;
    csc_v[CSC_PAR_ODD] = par_odd_q;
    csc_v[CSC_STOP2] = stop2_q;
    csc_v[CSC_SIZE_HI:CSC_SIZE_LO] = size_q[1:0];
  end

  // unmapped offsets read as zero
  assign rd_word = hit(a_off, OFF_DATA) ? DW'(rxbuf_q[7:0]) :
                   hit(a_off, OFF_CSA) ? DW'(csa_v) :
                   hit(a_off, OFF_CSB) ? DW'(csb_v) :
                   hit(a_off, OFF_CSC) ? DW'(csc_v) :
                   hit(a_off, OFF_BDLO) ? DW'(baud_q[7:0]) :
                   hit(a_off, OFF_BDHI) ? DW'(baud_q[DIV_W-1:8]) : '0;

  assign nbits = char_bits(size_q);
  assign os_max = sync_q ? OS_SYNC : (dbl_q ? OS_DOUBLE : OS_NORMAL);
  assign tick = (baud_cnt_q == '0);
  assign bound = tick & (ph_q == os_max);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      baud_cnt_q <= '0;
      ph_q <= '0;
    end else begin
      baud_cnt_q <= tick ? baud_q : baud_cnt_q - 1'b1;
      if (tick) begin
        ph_q <= (ph_q >= os_max) ? 4'h0 : ph_q + 4'h1;
      end
    end
  end

  // buffer to shifter at bit boundary
  assign load = txbuf_full_q & bound & ((tx_state_q == TX_IDLE) | (tx_left_q == 4'h1));
  assign frame_end = (tx_state_q == TX_SEND) & bound & (tx_left_q == 4'h1);
  // done when shifter drains into an empty buffer
  assign done_set = frame_end & ~txbuf_full_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q <= '1;
      tx_left_q <= '0;
      line_q <= 1'b1;
    end else if (load) begin
      tx_state_q <= TX_SEND;
      tx_sh_q <= build_frame(txbuf_q, nbits, par_en_q, par_odd_q);
      tx_left_q <= 4'h2 + nbits + {3'h0, par_en_q} + {3'h0, stop2_q};
      line_q <= 1'b0;
    end else if (frame_end) begin
      tx_state_q <= TX_IDLE;
      tx_left_q <= '0;
      line_q <= 1'b1;
    end else if ((tx_state_q == TX_SEND) & bound) begin
      tx_sh_q <= {1'b1, tx_sh_q[FRAME_W-1:1]};
      tx_left_q <= tx_left_q - 4'h1;
      line_q <= tx_sh_q[1];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      txbuf_full_q <= 1'b0;
      txbuf_q <= '0;
    end else if (wr_data) begin
      txbuf_full_q <= 1'b1;
      txbuf_q <= {tx9_q, i_hwdata[7:0]};
    end else if (load) begin
      txbuf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tx_done_q <= 1'b0;
    end else if (done_set) begin
      tx_done_q <= 1'b1;
    end else if (i_txdone_ack | (wr_csa & i_hwdata[CSA_TX_DONE])) begin
      tx_done_q <= 1'b0;
    end
  end

  // pin held until shifter and buffer drain
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tx_eff_q <= 1'b0;
    end else begin
      tx_eff_q <= tx_on_q | (tx_state_q == TX_SEND) | txbuf_full_q | load;
    end
  end

  // sync clock: rising at data change, falling mid bit
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      xck_q <= 1'b0;
    end else if (!sync_q) begin
      xck_q <= 1'b0;
    end else if (bound) begin
      xck_q <= 1'b1;
    end else if (tick) begin
      xck_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rxd;
      rx_s2_q <= rx_s1_q;
    end
  end

  assign rx_samp = tick & (rx_os_q == os_max);
  assign rx_store = (rx_state_q == RX_BITS) & rx_samp &
                    (rx_cnt_q == nbits + {3'h0, par_en_q});

  // start validated at mid bit, then one sample per period
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_os_q <= '0;
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
    end else if (!rx_on_q) begin
      rx_state_q <= RX_IDLE;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_os_q <= '0;
          if (!rx_s2_q) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick && rx_os_q == (os_max >> 1)) begin
            rx_state_q <= rx_s2_q ? RX_IDLE : RX_BITS;
            rx_os_q <= '0;
            rx_cnt_q <= '0;
          end else if (tick) begin
            rx_os_q <= rx_os_q + 4'h1;
          end
        end
        RX_BITS: begin
          if (rx_samp) begin
            rx_os_q <= '0;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q < nbits) begin
              rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
            end
            if (rx_store) begin
              rx_state_q <= RX_IDLE;
            end
          end else if (tick) begin
            rx_os_q <= rx_os_q + 4'h1;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // receiver off flushes the buffer; a new frame wins over a read
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_ready_q <= 1'b0;
      rxbuf_q <= '0;
    end else if (!rx_on_q) begin
      rx_ready_q <= 1'b0;
    end else if (rx_store) begin
      // store masked character with ninth bit
      rx_ready_q <= 1'b1;
      rxbuf_q <= 9'(rx_sh_q >> (BITS_MAX - nbits)) & low_mask(nbits);
    end else if (rd_data) begin
      rx_ready_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_e_q <= 1'b0;
      irq_d_q <= 1'b0;
      irq_r_q <= 1'b0;
    end else begin
      irq_e_q <= eie_q & ~txbuf_full_q;
      irq_d_q <= tdie_q & tx_done_q;
      irq_r_q <= rxie_q & rx_ready_q;
    end
  end

  assign o_hrdata = hrdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_txd = line_q;
  assign o_txd_oe = tx_eff_q;
  assign o_rxd_own = rx_on_q;
  assign o_xck = xck_q;
  assign o_xck_oe = sync_q;
  assign o_irq_empty = irq_e_q;
  assign o_irq_txdone = irq_d_q;
  assign o_irq_rxready = irq_r_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_tx_hold_pin: assert property (
    $fell(tx_on_q) && (txbuf_full_q || tx_state_q == TX_SEND) |=> o_txd_oe)
    else $error("pin released with pending data");
  // a control write may turn the transmitter back on, so both cycles must stay off
  a_tx_release: assert property (
    !tx_on_q && tx_state_q == TX_IDLE && !txbuf_full_q ##1 !tx_on_q |=> !o_txd_oe)
    else $error("idle disabled transmitter still owns pin");
  a_empty_write: assert property (wr_data |=> !csa_v[CSA_BUF_EMPTY])
    else $error("data write left buffer empty");
  a_empty_irq_lvl: assert property (
    eie_q && !txbuf_full_q ##1 eie_q && !txbuf_full_q |-> o_irq_empty)
    else $error("empty request missing");
  a_start_low: assert property (
    load && tx_state_q == TX_IDLE |=> !o_txd ##0 tx_state_q == TX_SEND)
    else $error("frame did not open with low start");
  a_idle_high: assert property (tx_state_q == TX_IDLE |-> o_txd)
    else $error("idle line not high");
  a_done_set: assert property (
    done_set |=> tx_done_q [*1] ##1 (tx_done_q || $past(i_txdone_ack) || $past(wr_csa)))
    else $error("tx done not set");
  a_done_clear: assert property (i_txdone_ack && !done_set |=> !tx_done_q)
    else $error("tx done not cleared on service");
  a_done_irq: assert property ($rose(tx_done_q) && tdie_q |=> o_irq_txdone)
    else $error("tx done request missing");
  // receiver switched off on the stop sample flushes instead of storing
  a_rx_store: assert property (
    rx_store && rx_on_q |=> rx_ready_q && rx_state_q == RX_IDLE)
    else $error("received frame not buffered");
  a_rx_mask: assert property (
    rx_ready_q && nbits < BITS_BYTE |-> (rxbuf_q[7:0] & ~low_mask(nbits)) == '0)
    else $error("upper receive bits not zero");

  c_frame_done: cover property (done_set);
  c_back_to_back: cover property (load && tx_state_q == TX_SEND);
  c_rx_frame: cover property (rx_store);
  c_done_irq: cover property (o_irq_txdone && i_txdone_ack);
endmodule : usart_core
`default_nettype wire

/* dv/remote_xcvr.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_xcvr (
  input wire logic i_mclk,
  input wire logic i_txd,
  output logic o_rxd
);
  int bit_clks = 16;
  int nbits = 8;
  int stops = 1;
  bit par_en = 1'b0;
  bit par_odd = 1'b0;
  int rx_count = 0;
  int cyc = 0;
  int last_end = 0;
  int gap = 0;
  logic [8:0] rx_data = '0;
  logic rx_par = 1'b0;
  logic stop_ok = 1'b0;
  initial o_rxd = 1'b1;
  always @(posedge i_mclk) cyc <= cyc + 1;
  // decode start, lsb first data, parity, stops
  always begin
    @(negedge i_txd);
    gap = cyc - last_end;
    repeat (bit_clks / 2) @(posedge i_mclk);
    rx_data = '0;
    stop_ok = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge i_mclk);
      rx_data[i] = i_txd;
    end
    if (par_en) begin
      repeat (bit_clks) @(posedge i_mclk);
      rx_par = i_txd;
    end
    for (int s = 0; s < stops; s++) begin
      repeat (bit_clks) @(posedge i_mclk);
      stop_ok = stop_ok & i_txd;
    end
    last_end = cyc;
    rx_count++;
  end
  // idle high line, low start, parity before stops
  task automatic send(input logic [8:0] d, input int st);
    logic p;
    p = par_odd;
    @(posedge i_mclk);
    o_rxd <= 1'b0;
    repeat (bit_clks) @(posedge i_mclk);
    for (int i = 0; i < nbits; i++) begin
      o_rxd <= d[i];
      p = p ^ d[i];
      repeat (bit_clks) @(posedge i_mclk);
    end
    if (par_en) begin
      o_rxd <= p;
      repeat (bit_clks) @(posedge i_mclk);
    end
    o_rxd <= 1'b1;
    repeat (bit_clks * st) @(posedge i_mclk);
  endtask : send
endmodule : remote_xcvr
`default_nettype wire

/* dv/serial_usart_tx_rx_path_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_usart_tx_rx_path_bench;
  import usart_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic ack = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic rxd;
  wire logic txd;
  wire logic txd_oe;
  wire logic rxd_own;
  wire logic sync_clock_pin;
  wire logic xck_oe;
  wire logic irq_empty;
  wire logic irq_txdone;
  wire logic irq_rxready;
  wire logic txd_line;
  int checks = 0;
  int miscompares = 0;
  // pull-up keeps the line high once the port is released
  assign txd_line = (txd_oe === 1'b1) ? txd : 1'b1;
  always #12.5 mclk = ~mclk;
  usart_core #(.DIV_W(12)) u_usart_core (.i_mclk(mclk), .i_rst_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_rxd(rxd), .i_txdone_ack(ack), .o_txd(txd), .o_txd_oe(txd_oe),
    .o_rxd_own(rxd_own), .o_xck(sync_clock_pin), .o_xck_oe(xck_oe), .o_irq_empty(irq_empty),
    .o_irq_txdone(irq_txdone), .o_irq_rxready(irq_rxready));
  remote_xcvr u_remote_xcvr (.i_mclk(mclk), .i_txd(txd_line), .o_rxd(rxd));
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(a, 1'b0, 32'h00000000, x);
    check(nm, exp, x);
  endtask : rdc
  task automatic poll(input int b);
    logic [31:0] x;
    do bus(OFF_CSA, 1'b0, 32'h00000000, x); while (x[b] !== 1'b1);
  endtask : poll
  task automatic waitf(input int n);
    while (u_remote_xcvr.rx_count < n) @(posedge mclk);
  endtask : waitf
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report();
  end
  initial begin
    int n;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdc("csa_reset", OFF_CSA, 32'h20);
    rdc("unmapped", 8'h18, 32'h0);
    check("txd_oe_off", 1'b0, txd_oe);
    check("hresp", 1'b0, hresp);
    // config goes in before any character is sent
    wr(OFF_BDLO, 32'h0);
    wr(OFF_BDHI, 32'h0);
    wr(OFF_CSC, 32'h26);
    wr(OFF_CSB, 32'hF8);
    rdc("csb", OFF_CSB, 32'hF8);
    @(negedge mclk);
    check("txd_oe", 1'b1, txd_oe);
    check("rxd_own", 1'b1, rxd_own);
    check("irq_empty", 1'b1, irq_empty);
    u_remote_xcvr.par_en = 1'b1;
    wr(OFF_DATA, 32'hA7);
    poll(CSA_BUF_EMPTY);
    wr(OFF_DATA, 32'h3C);
    rdc("csa_busy", OFF_CSA, 32'h00);
    @(negedge mclk);
    check("irq_empty_full", 1'b0, irq_empty);
    waitf(1);
    check("frame1", 32'hA7, u_remote_xcvr.rx_data);
    check("parity1", ^8'hA7, u_remote_xcvr.rx_par);
    waitf(2);
    check("frame2", 32'h3C, u_remote_xcvr.rx_data);
    check("no_gap", 1'b1, u_remote_xcvr.gap < u_remote_xcvr.bit_clks);
    check("stop", 1'b1, u_remote_xcvr.stop_ok);
    poll(CSA_TX_DONE);
    rdc("csa_done", OFF_CSA, 32'h60);
    check("irq_txdone", 1'b1, irq_txdone);
    wr(OFF_CSA, 32'h40);
    rdc("csa_w1c", OFF_CSA, 32'h20);
    wr(OFF_CSC, 32'h30);
    u_remote_xcvr.nbits = 5;
    u_remote_xcvr.par_odd = 1'b1;
    wr(OFF_DATA, 32'hFF);
    waitf(3);
    check("frame5", 32'h1F, u_remote_xcvr.rx_data);
    check("parity5", (^5'h1F) ^ 1'b1, u_remote_xcvr.rx_par);
    poll(CSA_TX_DONE);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    rdc("csa_ack", OFF_CSA, 32'h20);
    u_remote_xcvr.send(9'h015, 1);
    poll(CSA_RX_READY);
    check("irq_rxready", 1'b1, irq_rxready);
    rdc("rx5", OFF_DATA, 32'h15);
    rdc("csa_read", OFF_CSA, 32'h20);
    u_remote_xcvr.nbits = 9;
    u_remote_xcvr.stops = 2;
    u_remote_xcvr.par_en = 1'b0;
    u_remote_xcvr.par_odd = 1'b0;
    wr(OFF_CSC, 32'h0E);
    wr(OFF_CSB, 32'hFD);
    wr(OFF_DATA, 32'h3C);
    waitf(4);
    check("frame9", 32'h13C, u_remote_xcvr.rx_data);
    check("stop2", 1'b1, u_remote_xcvr.stop_ok);
    fork
      begin
        u_remote_xcvr.send(9'h1C3, 1);
        u_remote_xcvr.send(9'h0A5, 1);
      end
    join_none
    poll(CSA_RX_READY);
    rdc("csb_nine", OFF_CSB, 32'hFF);
    rdc("rx9", OFF_DATA, 32'hC3);
    poll(CSA_RX_READY);
    rdc("csb_nine2", OFF_CSB, 32'hFD);
    rdc("rx9b", OFF_DATA, 32'hA5);
    u_remote_xcvr.nbits = 8;
    u_remote_xcvr.stops = 1;
    u_remote_xcvr.bit_clks = 8;
    wr(OFF_CSC, 32'h06);
    wr(OFF_CSB, 32'hF8);
    wr(OFF_CSA, 32'h02);
    wr(OFF_DATA, 32'h5A);
    waitf(5);
    check("frame_dbl", 32'h5A, u_remote_xcvr.rx_data);
    wr(OFF_DATA, 32'hC3);
    poll(CSA_BUF_EMPTY);
    wr(OFF_CSB, 32'hF0);
    @(negedge mclk);
    check("oe_pending", 1'b1, txd_oe);
    waitf(6);
    check("frame_last", 32'hC3, u_remote_xcvr.rx_data);
    repeat (16) @(negedge mclk);
    check("oe_release", 1'b0, txd_oe);
    wr(OFF_DATA, 32'h11);
    repeat (200) @(posedge mclk);
    check("no_frame_off", 6, u_remote_xcvr.rx_count);
    u_remote_xcvr.bit_clks = 2;
    wr(OFF_CSC, 32'h46);
    wr(OFF_CSB, 32'hF8);
    @(negedge mclk);
    check("xck_oe", 1'b1, xck_oe);
    wr(OFF_DATA, 32'h66);
    n = 0;
    while (sync_clock_pin !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    check("xck_runs", 1'b1, sync_clock_pin);
    waitf(7);
    check("frame_sync", 32'h66, u_remote_xcvr.rx_data);
    final_report();
  end
endmodule : serial_usart_tx_rx_path_bench
`default_nettype wire
